// ===== design/char_lcd_nibble_write_port.sv
/*
 * Holds the constants package and the top module of the display module's
 * nibble write port: pin sampling, byte assembly, instruction decode,
 * display memory, glyph addressing and a registered dot view port.
 * Assumes host pins arrive asynchronously to core_clk and that each
 * strobe high and low phase lasts far longer than four core_clk cycles.
 */
`timescale 1ns/1ps

// Functional notes
// - register select decides instruction or character data.
// - data travels over the upper four lines.
// - glyph RAM holds eight five-by-eight characters.
// - eight row bytes per glyph, low five bits.
// - pattern bit one lit, zero dark.
// - character code of glyph index shows that glyph.
package lcd_pkg;
   localparam int NIB_W = 4;
   localparam int BYTE_W = 8;
   localparam int DOT_W = 5;
   localparam int ROW_W = 3;
   localparam int GLYPH_ADDR_W = 6;
   localparam int GLYPH_DEPTH = 64;
   localparam int POS_W = 5;
   localparam int DISP_DEPTH = 32;
   localparam logic RS_INSTR = 1'b0;
   localparam logic RS_DATA = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   localparam logic [7:0] CMD_CLEAR = 8'h01;
   localparam int CMD_DISP_BIT = 7;
   localparam int CMD_GLYPH_BIT = 6;
   localparam logic [7:0] CHAR_BLANK = 8'h20;
   localparam logic [4:0] GLYPH_CODE_HIGH = 5'h00;
   localparam logic [4:0] DOTS_DARK = 5'h00;

   // true for the eight codes that select a user glyph
   function automatic logic is_glyph(input logic [7:0] code);
      return code[7:3] == GLYPH_CODE_HIGH;
   endfunction : is_glyph
endpackage : lcd_pkg

module char_lcd_nibble_write_port (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic register_select,
   input wire logic read_write,
   input wire logic strobe,
   input wire logic [3:0] data_upper,
   input wire logic [4:0] view_pos,
   input wire logic [2:0] view_row,
   output logic [4:0] view_dots,
   output logic view_glyph,
   output logic [7:0] view_code,
   output logic byte_valid,
   output logic [7:0] byte_value,
   output logic byte_is_data
);
   logic [6:0] sync1, sync2, sync3, pin;
   logic stb_fall;
   logic phase;
   logic [3:0] upper;
   logic glyph_mode;
   logic [5:0] glyph_addr;
   logic [4:0] cursor;
   logic [7:0] disp_mem [lcd_pkg::DISP_DEPTH];
   logic glyph_we, disp_we, is_instr, cmd_clear;
   logic [7:0] cur_code;
   logic [4:0] glyph_rd;

   // three-stage pin sampler; a change counts once stages two and three agree
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         sync1 <= 7'h00;
         sync2 <= 7'h00;
         sync3 <= 7'h00;
         pin <= 7'h00;
      end
      else
      begin
         sync1 <= {strobe, read_write, register_select, data_upper};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < $bits(sync1); i++)
            if (sync2[i] == sync3[i])
               pin[i] <= sync3[i];
      end

   // nibble taken on the settled falling strobe of a write transfer
   assign stb_fall = pin[6] && sync2[6] == 1'b0 && sync3[6] == 1'b0
                     && pin[5] == lcd_pkg::RW_WRITE;

   // pair nibbles, upper first, into one byte; reads are ignored
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         phase <= 1'b0;
         upper <= 4'h0;
         byte_valid <= 1'b0;
         byte_value <= 8'h00;
         byte_is_data <= 1'b0;
      end
      else
      begin
         byte_valid <= 1'b0;
         if (stb_fall && !phase)
         begin
            upper <= pin[3:0];
            phase <= 1'b1;
         end
         else if (stb_fall)
         begin
            byte_value <= {upper, pin[3:0]};
            byte_is_data <= pin[4];
            byte_valid <= 1'b1;
            phase <= 1'b0;
         end
      end

   // select decides whether a byte is an instruction or character data
   assign is_instr = byte_valid && byte_is_data == lcd_pkg::RS_INSTR;
   assign glyph_we = byte_valid && byte_is_data == lcd_pkg::RS_DATA && glyph_mode;
   assign disp_we = byte_valid && byte_is_data == lcd_pkg::RS_DATA && !glyph_mode;
   assign cmd_clear = is_instr && byte_value == lcd_pkg::CMD_CLEAR;

   // address state: glyph address, cursor, and which memory takes data
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         glyph_mode <= 1'b0;
         glyph_addr <= 6'h00;
         cursor <= 5'h00;
      end
      else if (is_instr && byte_value[lcd_pkg::CMD_DISP_BIT])
      begin
         cursor <= byte_value[4:0];
         glyph_mode <= 1'b0;
      end
      else if (is_instr && byte_value[lcd_pkg::CMD_GLYPH_BIT])
      begin
         glyph_addr <= byte_value[5:0];
         glyph_mode <= 1'b1;
      end
      else if (cmd_clear)
      begin
         cursor <= 5'h00;
         glyph_mode <= 1'b0;
      end
      else if (glyph_we)
         glyph_addr <= glyph_addr + 6'h01;
      else if (disp_we)
         cursor <= cursor + 5'h01;

   // display memory: character codes per screen position
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         for (int i = 0; i < lcd_pkg::DISP_DEPTH; i++)
            disp_mem[i] <= lcd_pkg::CHAR_BLANK;
      end
      else if (cmd_clear)
      begin
         for (int i = 0; i < lcd_pkg::DISP_DEPTH; i++)
            disp_mem[i] <= lcd_pkg::CHAR_BLANK;
      end
      else if (disp_we)
         disp_mem[cursor] <= byte_value;

   assign cur_code = disp_mem[view_pos];

   glyph_store u_glyph (
      .core_clk(core_clk),
      .nrst(nrst),
      .wr_en(glyph_we),
      .wr_addr(glyph_addr),
      .wr_dots(byte_value[4:0]),
      .rd_addr({cur_code[2:0], view_row}),
      .rd_dots(glyph_rd)
   );

   // view port: glyph codes show their stored rows, a one bit is a lit dot
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         view_dots <= 5'h00;
         view_glyph <= 1'b0;
         view_code <= 8'h00;
      end
      else
      begin
         view_code <= cur_code;
         view_glyph <= lcd_pkg::is_glyph(cur_code);
         view_dots <= lcd_pkg::is_glyph(cur_code) ? glyph_rd : lcd_pkg::DOTS_DARK;
      end

   a_instr_no_store: assert property (@(posedge core_clk) disable iff (!nrst)
      is_instr |-> !glyph_we && !disp_we)
      else $error("instruction byte stored as data");
   a_data_select: assert property (@(posedge core_clk) disable iff (!nrst)
      (glyph_we || disp_we) |-> byte_is_data == lcd_pkg::RS_DATA && glyph_we != disp_we)
      else $error("data write without select high");
   a_nibble_pair: assert property (@(posedge core_clk) disable iff (!nrst)
      stb_fall && phase |=> byte_valid && byte_value[3:0] == $past(pin[3:0])
      && byte_value[7:4] == $past(upper) && !phase)
      else $error("nibbles paired wrongly");
   a_glyph_step: assert property (@(posedge core_clk) disable iff (!nrst)
      glyph_we |=> glyph_addr == $past(glyph_addr) + 6'h01)
      else $error("glyph address did not advance");
   a_glyph_base: assert property (@(posedge core_clk) disable iff (!nrst)
      is_instr && !byte_value[7] && byte_value[6] |=> glyph_mode
      && glyph_addr == $past(byte_value[5:0]))
      else $error("glyph address not loaded");
   a_glyph_show: assert property (@(posedge core_clk) disable iff (!nrst)
      lcd_pkg::is_glyph(cur_code) |=> view_glyph && view_code == $past(cur_code))
      else $error("glyph code not shown as glyph");
   a_dot_map: assert property (@(posedge core_clk) disable iff (!nrst)
      ##1 view_dots == ($past(lcd_pkg::is_glyph(cur_code)) ? $past(glyph_rd)
      : lcd_pkg::DOTS_DARK))
      else $error("dot pattern mismatch");
endmodule : char_lcd_nibble_write_port

// ===== design/glyph_store.sv
/*
 * Glyph pattern store: eight glyphs of eight rows, five dots per row,
 * in flip-flops. Assumes one writer on core_clk and a combinational reader.
 */
`timescale 1ns/1ps

module glyph_store (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [5:0] wr_addr,
   input wire logic [4:0] wr_dots,
   input wire logic [5:0] rd_addr,
   output logic [4:0] rd_dots
);
   logic [4:0] mem [lcd_pkg::GLYPH_DEPTH];

   // row store; only the low five pattern bits are kept
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         for (int i = 0; i < lcd_pkg::GLYPH_DEPTH; i++)
            mem[i] <= 5'h00;
      end
      else if (wr_en)
         mem[wr_addr] <= wr_dots;

   assign rd_dots = mem[rd_addr];

   a_row_written: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_en |=> mem[$past(wr_addr)] == $past(wr_dots))
      else $error("glyph row not written");
endmodule : glyph_store

// ===== tb/lcd_host_model.sv
/*
 * Host side of the nibble write port: drives select, read/write, strobe
 * and the upper data lines, timed by its own tick_timer.
 * Assumes the bench calls its tasks in sequence and may shorten the tick
 * through the prescale and period parameters to keep a run short.
 */
`timescale 1ns/1ps

module lcd_host_model #(
   parameter int TICK_PRESCALE = 128,
   parameter int TICK_PERIOD = 124
) (
   input wire logic core_clk,
   output logic register_select,
   output logic read_write,
   output logic strobe,
   output logic [3:0] data_upper
);
   int pre_cnt = 0;
   int per_cnt = 0;
   logic tick = 1'b0;

   // tick_timer: prescaler, then period count, one-cycle tick per period
   always @(posedge core_clk)
   begin
      tick <= 1'b0;
      if (pre_cnt == TICK_PRESCALE - 1)
      begin
         pre_cnt <= 0;
         if (per_cnt == TICK_PERIOD)
         begin
            per_cnt <= 0;
            tick <= 1'b1;
         end
         else
            per_cnt <= per_cnt + 1;
      end
      else
         pre_cnt <= pre_cnt + 1;
   end

   // fixed wait of whole ticks; the busy indication is never read
   task automatic wait_ticks(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         while (tick !== 1'b1)
            @(posedge core_clk);
      end
   endtask : wait_ticks
   // idle levels at time zero
   initial
   begin
      register_select = 1'b0;
      read_write = 1'b0;
      strobe = 1'b0;
      data_upper = 4'h0;
   end

   // one nibble send: set up lines, strobe high two ticks, hold, then scramble data
   task automatic nib(input logic rs, input logic rw, input logic [3:0] n);
      @(posedge core_clk);
      #1;
      register_select = rs;
      read_write = rw;
      data_upper = n;
      repeat (6) @(posedge core_clk);
      #1 strobe = 1'b1;
      wait_ticks(2);
      #1 strobe = 1'b0;
      repeat (6) @(posedge core_clk);
      #1 data_upper = ~n; // old value no longer holds
   endtask : nib

   // whole byte as two write sends, upper nibble first
   task automatic send_byte(input logic rs, input logic [7:0] b);
      nib(rs, 1'b0, b[7:4]);
      nib(rs, 1'b0, b[3:0]);
      wait_ticks(1);
   endtask : send_byte
endmodule : lcd_host_model

// ===== tb/test_char_lcd_nibble_write_port.sv
/*
 * Self-checking bench for the nibble write port with a host model.
 * Assumes the package and design modules are compiled first.
 */
`timescale 1ns/1ps

module test_char_lcd_nibble_write_port;
   logic core_clk, nrst, register_select, read_write, strobe, view_glyph, byte_valid;
   logic byte_is_data;
   logic [3:0] data_upper;
   logic [4:0] view_pos, view_dots;
   logic [2:0] view_row;
   logic [7:0] view_code, byte_value;
   logic [8:0] expq[$];
   logic [4:0] pat[64];
   int errors = 0;
   int check_count = 0;

   char_lcd_nibble_write_port dut (.core_clk(core_clk), .nrst(nrst),
      .register_select(register_select), .read_write(read_write), .strobe(strobe),
      .data_upper(data_upper), .view_pos(view_pos), .view_row(view_row),
      .view_dots(view_dots), .view_glyph(view_glyph), .view_code(view_code),
      .byte_valid(byte_valid), .byte_value(byte_value), .byte_is_data(byte_is_data));
   // host tick shortened to eight clock cycles so the run stays short
   lcd_host_model #(.TICK_PRESCALE(2), .TICK_PERIOD(3)) host (.core_clk(core_clk),
      .register_select(register_select),
      .read_write(read_write), .strobe(strobe), .data_upper(data_upper));

   // clock generator
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // compare and count
   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // note the expected byte, then send it
   task automatic put(input logic rs, input logic [7:0] b);
      expq.push_back({rs, b});
      host.send_byte(rs, b);
   endtask : put

   // look at one screen position and glyph row
   task automatic look(input int p, input int r, input logic [7:0] code, input logic [4:0] dots);
      @(posedge core_clk);
      #1;
      view_pos = 5'(p);
      view_row = 3'(r);
      @(posedge core_clk);
      #1;
      chk("view_code", {1'b0, code}, {1'b0, view_code});
      chk("view_glyph", {8'h00, code < 8'h08}, {8'h00, view_glyph});
      chk("view_dots", {4'h0, dots}, {4'h0, view_dots});
   endtask : look

   // watch assembled bytes and take the oldest note
   always @(negedge core_clk)
      if (byte_valid === 1'b1)
         chk("byte", expq.size() > 0 ? expq.pop_front() : 9'h1FF, {byte_is_data, byte_value});

   // watchdog
   initial
   begin
      #80000;
      errors++;
      end_sim();
   end

   // main sequence
   initial
   begin
      logic [7:0] b;
      nrst = 1'b0;
      view_pos = 5'h00;
      view_row = 3'h0;
      void'($urandom(45));
      repeat (12) @(posedge core_clk);
      #1 nrst = 1'b1;
      host.wait_ticks(100);
      put(1'b0, 8'h01);
      put(1'b0, 8'h40);
      for (int i = 0; i < 64; i++)
      begin
         b = 8'($urandom);
         pat[i] = b[4:0];
         put(1'b1, b);
      end
      host.nib(1'b1, 1'b1, 4'hF);
      put(1'b0, 8'h80);
      for (int c = 0; c < 8; c++)
         put(1'b1, 8'(c));
      put(1'b1, 8'h41);
      for (int p = 0; p < 8; p++)
         for (int r = 0; r < 8; r++)
            look(p, r, 8'(p), pat[p * 8 + r]);
      look(8, 2, 8'h41, 5'h00);
      look(9, 0, 8'h20, 5'h00);
      put(1'b0, 8'h8A);
      put(1'b1, 8'h05);
      look(10, 4, 8'h05, pat[44]);
      put(1'b0, 8'h01);
      repeat (3) @(posedge core_clk);
      look(3, 0, 8'h20, 5'h00);
      chk("pending", 9'h000, 9'(expq.size()));
      end_sim();
   end
endmodule : test_char_lcd_nibble_write_port
